//--- hdl/lsb_marker_regs.vh
// Register indices, field positions, reset values and timing counts for the trim and marker block.
`ifndef LSB_MARKER_REGS_VH
`define LSB_MARKER_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_BANK2_TRIM_PHASE0   10'h122
`define IDX_BANK2_TRIM_PHASE90  10'h123
`define IDX_BANK3_TRIM_PHASE0   10'h132
`define IDX_BANK3_TRIM_PHASE90  10'h133
`define IDX_BANK4_TRIM_PHASE0   10'h142
`define IDX_BANK4_TRIM_PHASE90  10'h143
`define IDX_BANK5_TRIM_PHASE0   10'h152
`define IDX_BANK5_TRIM_PHASE90  10'h153
`define IDX_SAMPLE_LSB_CONTROL  10'h160
`define IDX_SAMPLE_PATH_CONTROL 10'h170
`define IDX_SAMPLE_PATH_STATUS  10'h171

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LSB_MARKER_EN_BIT       0
`define PATH_PHASE_NEG90_BIT    0
`define PATH_CAL_STATE_EN_BIT   1
`define PATH_MARKER_RECV_EN_BIT 2
`define PATH_MODE_8BIT_BIT      3
`define PATH_FIELD_MSB          3
`define STAT_MARKER_LEVEL_BIT   0
`define STAT_FUSE_LOADED_BIT    1
`define SAMPLE_LSB_CONTROL_RST  8'h00
`define SAMPLE_PATH_CONTROL_RST 4'h0
`define TRIM_RST                8'h00
`define ILA_CS_VALUE            2'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define CONVERTER_LATENCY_CYC   12
`define PIN_SYNC_STAGES         2
`define MARKER_DELAY_CYC        (`CONVERTER_LATENCY_CYC - `PIN_SYNC_STAGES)

`endif

//--- hdl/bank_timing_trim_and_lsb_marker.v
// Bank sampling-time trim registers and output-sample LSB marker insertion behind an APB slave.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_marker_regs.vh"

module bank_timing_trim_and_lsb_marker (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Factory fuse values, banks 2 to 5, bank 2 in the low byte
  input  wire [31:0] fuse_trim_phase0,
  input  wire [31:0] fuse_trim_phase90,
  // Trim applied to banks 2 to 5, bank 2 in the low byte
  output reg  [31:0] bank_trim,
  // Sample stream from the converter core and the marker pin
  input  wire        marker_pin,
  input  wire        cal_status,
  input  wire [11:0] sample_in,
  input  wire        sample_valid_in,
  // Sample stream toward the transport layer
  output reg  [11:0] sample_out,
  output reg         sample_valid_out,
  output reg  [1:0]  ila_cs_field
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  wire [31:0] trim0_all;
  wire [31:0] trim90_all;
  wire [3:0]  wr_trim0;
  wire [3:0]  wr_trim90;
  reg         marker_en_reg;
  reg  [6:0]  lsb_spare_reg;
  reg  [`PATH_FIELD_MSB:0] path_reg;
  reg         fuse_loaded_reg;
  reg         sync1_reg;
  reg         sync2_reg;
  reg  [`MARKER_DELAY_CYC-1:0] marker_dly_reg;
  reg  [31:0] rdata_next;
  reg         hit_next;

  wire [9:0]  idx        = paddr[11:2];
  wire        access     = psel & penable & pready;
  wire        wr_ok      = access & pwrite & ~pslverr & pstrb[0];
  wire        load_fuse  = ~fuse_loaded_reg;
  wire        phase_neg90 = path_reg[`PATH_PHASE_NEG90_BIT];
  wire        cal_en      = path_reg[`PATH_CAL_STATE_EN_BIT];
  wire        recv_en     = path_reg[`PATH_MARKER_RECV_EN_BIT];
  wire        mode_8bit   = path_reg[`PATH_MODE_8BIT_BIT];
  wire        marker_now  = marker_dly_reg[`MARKER_DELAY_CYC-1];

  // --------------------------------------------------------------------------
  // Read mux and address decode
  // --------------------------------------------------------------------------
  // Reserved bits of the control byte are kept so they read back as written.
  always @* begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b1;
    case (idx)
      `IDX_BANK2_TRIM_PHASE0:   rdata_next[7:0] = trim0_all[7:0];
      `IDX_BANK2_TRIM_PHASE90:  rdata_next[7:0] = trim90_all[7:0];
      `IDX_BANK3_TRIM_PHASE0:   rdata_next[7:0] = trim0_all[15:8];
      `IDX_BANK3_TRIM_PHASE90:  rdata_next[7:0] = trim90_all[15:8];
      `IDX_BANK4_TRIM_PHASE0:   rdata_next[7:0] = trim0_all[23:16];
      `IDX_BANK4_TRIM_PHASE90:  rdata_next[7:0] = trim90_all[23:16];
      `IDX_BANK5_TRIM_PHASE0:   rdata_next[7:0] = trim0_all[31:24];
      `IDX_BANK5_TRIM_PHASE90:  rdata_next[7:0] = trim90_all[31:24];
      `IDX_SAMPLE_LSB_CONTROL:  rdata_next[7:0] = {lsb_spare_reg, marker_en_reg};
      `IDX_SAMPLE_PATH_CONTROL: rdata_next[`PATH_FIELD_MSB:0] = path_reg;
      `IDX_SAMPLE_PATH_STATUS: begin
        rdata_next[`STAT_MARKER_LEVEL_BIT] = marker_now;
        rdata_next[`STAT_FUSE_LOADED_BIT]  = fuse_loaded_reg;
      end
      default: hit_next = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      hit_next = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // APB handshake
  // --------------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle so every bus output is a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit_next;
      prdata  <= (hit_next && !pwrite) ? rdata_next : 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Trim registers
  // --------------------------------------------------------------------------
  // Write strobes, one per trim byte, bank 2 in bit 0. A strobe needs the same aligned,
  // mapped access with the low byte lane enabled that every other register write needs.
  assign wr_trim0[0]  = wr_ok && (idx == `IDX_BANK2_TRIM_PHASE0);
  assign wr_trim0[1]  = wr_ok && (idx == `IDX_BANK3_TRIM_PHASE0);
  assign wr_trim0[2]  = wr_ok && (idx == `IDX_BANK4_TRIM_PHASE0);
  assign wr_trim0[3]  = wr_ok && (idx == `IDX_BANK5_TRIM_PHASE0);
  assign wr_trim90[0] = wr_ok && (idx == `IDX_BANK2_TRIM_PHASE90);
  assign wr_trim90[1] = wr_ok && (idx == `IDX_BANK3_TRIM_PHASE90);
  assign wr_trim90[2] = wr_ok && (idx == `IDX_BANK4_TRIM_PHASE90);
  assign wr_trim90[3] = wr_ok && (idx == `IDX_BANK5_TRIM_PHASE90);

  // The fuse word is a level, so it is loaded by a clocked step after reset release,
  // never through the asynchronous reset. This flag marks that the load has happened.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_loaded_reg <= 1'b0;
    end else begin
      fuse_loaded_reg <= 1'b1;
    end
  end

  // One cell per bank and phase. Both phases are kept, so switching the phase never
  // loses a software adjustment made to the other one.
  trim_cell #(.WIDTH(8)) i_trim_bank2_phase0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase0[7:0]),
    .write       (wr_trim0[0]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim0_all[7:0])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank2_phase90 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase90[7:0]),
    .write       (wr_trim90[0]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim90_all[7:0])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank3_phase0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase0[15:8]),
    .write       (wr_trim0[1]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim0_all[15:8])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank3_phase90 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase90[15:8]),
    .write       (wr_trim90[1]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim90_all[15:8])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank4_phase0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase0[23:16]),
    .write       (wr_trim0[2]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim0_all[23:16])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank4_phase90 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase90[23:16]),
    .write       (wr_trim90[2]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim90_all[23:16])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank5_phase0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase0[31:24]),
    .write       (wr_trim0[3]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim0_all[31:24])
  );

  trim_cell #(.WIDTH(8)) i_trim_bank5_phase90 (
    .pclk        (pclk),
    .presetn     (presetn),
    .load        (load_fuse),
    .fuse_value  (fuse_trim_phase90[31:24]),
    .write       (wr_trim90[3]),
    .write_value (pwdata[7:0]),
    .trim_reg    (trim90_all[31:24])
  );

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lsb_spare_reg, marker_en_reg} <= `SAMPLE_LSB_CONTROL_RST;
      path_reg <= `SAMPLE_PATH_CONTROL_RST;
    end else if (wr_ok) begin
      if (idx == `IDX_SAMPLE_LSB_CONTROL) begin
        {lsb_spare_reg, marker_en_reg} <= pwdata[7:0];
      end
      if (idx == `IDX_SAMPLE_PATH_CONTROL) begin
        path_reg <= pwdata[`PATH_FIELD_MSB:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Applied trim
  // --------------------------------------------------------------------------
  // Only the trim of the selected clock phase reaches the bank.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_trim <= 32'h0000_0000;
    end else begin
      bank_trim <= phase_neg90 ? trim90_all : trim0_all;
    end
  end

  // --------------------------------------------------------------------------
  // Marker pin path
  // --------------------------------------------------------------------------
  // The pin is asynchronous, so two flops precede any use. The synchroniser counts
  // toward the total so the marker lands with the sample taken at the same instant.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg      <= 1'b0;
      sync2_reg      <= 1'b0;
      marker_dly_reg <= {`MARKER_DELAY_CYC{1'b0}};
    end else begin
      sync1_reg      <= marker_pin;
      sync2_reg      <= sync1_reg;
      marker_dly_reg <= {marker_dly_reg[`MARKER_DELAY_CYC-2:0], sync2_reg & recv_en};
    end
  end

  // --------------------------------------------------------------------------
  // Sample LSB insertion
  // --------------------------------------------------------------------------
  // Marker outranks calibration status; with neither enabled the LSB passes untouched.
  // In 8-bit mode the sample occupies bits 7:0 and bits 11:8 read zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out       <= 12'h000;
      sample_valid_out <= 1'b0;
      ila_cs_field     <= `ILA_CS_VALUE;
    end else begin
      sample_valid_out <= sample_valid_in;
      ila_cs_field     <= `ILA_CS_VALUE;
      sample_out[11:8] <= mode_8bit ? 4'h0 : sample_in[11:8];
      sample_out[7:1]  <= sample_in[7:1];
      if (marker_en_reg) begin
        sample_out[0] <= marker_now;
      end else if (cal_en) begin
        sample_out[0] <= cal_status;
      end else begin
        sample_out[0] <= sample_in[0];
      end
    end
  end

endmodule // bank_timing_trim_and_lsb_marker

// ----------------------------------------------------------------------------
// One trim byte
// ----------------------------------------------------------------------------
module trim_cell #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Load and write controls
  input  wire             load,
  input  wire [WIDTH-1:0] fuse_value,
  input  wire             write,
  input  wire [WIDTH-1:0] write_value,
  // Stored trim
  output reg  [WIDTH-1:0] trim_reg
);

  // The fuse byte enters in the load cycle only; a software write in that same cycle
  // wins, so an early write is never overwritten by the factory value.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_reg <= `TRIM_RST;
    end else if (write) begin
      trim_reg <= write_value;
    end else if (load) begin
      trim_reg <= fuse_value;
    end
  end

endmodule // trim_cell
`default_nettype wire

//--- verif/lsb_marker_monitor.sv
// Port-level assertions for the trim and LSB marker block.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_marker_regs.vh"
module lsb_marker_monitor (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sample side
  input wire logic        marker_pin,
  input wire logic [11:0] sample_in,
  input wire logic [11:0] sample_out,
  input wire logic [1:0]  ila_cs_field
);
  logic       men_reg;
  logic [3:0] ctl_reg;
  logic [3:0] quiet_reg;
  wire        wr = psel && penable && pready && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
  wire        settled = quiet_reg == 4'hf;
  // Shadow of the control bits; checks wait until the 12-cycle marker pipe has drained after a write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      men_reg   <= 1'b0;
      ctl_reg   <= 4'h0;
      quiet_reg <= 4'h0;
    end else begin
      if (wr && paddr[11:2] == `IDX_SAMPLE_LSB_CONTROL) men_reg <= pwdata[`LSB_MARKER_EN_BIT];
      if (wr && paddr[11:2] == `IDX_SAMPLE_PATH_CONTROL) ctl_reg <= pwdata[3:0];
      quiet_reg <= wr ? 4'h0 : (settled ? quiet_reg : quiet_reg + 4'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  chk_ready_wait: assert property ($rose(penable) && psel |-> s_one_wait)
    else $error("access phase not answered after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  chk_err_misalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  chk_cs_zero: assert property (ila_cs_field == `ILA_CS_VALUE)
    else $error("control bits per sample not zero");
  chk_marker_lsb: assert property (settled && men_reg && ctl_reg[2] |-> sample_out[0] == $past(marker_pin, 13))
    else $error("marker missing or mistimed on the sample LSB");
  chk_lsb_plain: assert property (settled && !men_reg && !ctl_reg[1] |-> sample_out[0] == $past(sample_in[0]))
    else $error("sample LSB modified with no control bit enabled");
  chk_mode8_top: assert property (settled && ctl_reg[3] |-> sample_out[11:8] == 4'h0)
    else $error("upper bits set in 8-bit mode");
  chk_data_wide: assert property (settled && !ctl_reg[3] |-> sample_out[11:1] == $past(sample_in[11:1]))
    else $error("upper eleven bits not passed in 12-bit mode");
endmodule // lsb_marker_monitor
`default_nettype wire

//--- verif/sample_source.sv
// Converter-core sample source feeding the block's stream input.
`timescale 1ns/1ps
`default_nettype none
module sample_source (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Undecimated stream, one sample each cycle
  output var  logic [11:0] sample_in,
  output var  logic        sample_valid_in
);
  // An odd step flips the LSB every cycle, so a stuck or substituted LSB shows at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_in       <= 12'h000;
      sample_valid_in <= 1'b0;
    end else begin
      sample_in       <= sample_in + 12'h5a5;
      sample_valid_in <= 1'b1;
    end
  end
endmodule // sample_source
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the trim and LSB marker block.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_marker_regs.vh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        marker_pin, cal_status, sample_valid_in, sample_valid_out;
  logic [11:0] paddr, sample_in, sample_out, s;
  logic [31:0] pwdata, prdata, bank_trim;
  logic [31:0] fuse_trim_phase0 = 32'h44332211;
  logic [31:0] fuse_trim_phase90 = 32'h88776655;
  logic [3:0]  pstrb;
  logic [1:0]  ila_cs_field;
  int          fail_count, check_count, i;

  bank_timing_trim_and_lsb_marker i_bank_timing_trim_and_lsb_marker (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pstrb             (pstrb),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .fuse_trim_phase0  (fuse_trim_phase0),
    .fuse_trim_phase90 (fuse_trim_phase90),
    .bank_trim         (bank_trim),
    .marker_pin        (marker_pin),
    .cal_status        (cal_status),
    .sample_in         (sample_in),
    .sample_valid_in   (sample_valid_in),
    .sample_out        (sample_out),
    .sample_valid_out  (sample_valid_out),
    .ila_cs_field      (ila_cs_field)
  );
  sample_source i_sample_source (
    .pclk            (pclk),
    .presetn         (presetn),
    .sample_in       (sample_in),
    .sample_valid_in (sample_valid_in)
  );

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; the answer is taken at the edge where pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [1:0] lo, input logic st,
                     input logic [7:0] wd, input logic [7:0] ed, input logic ee);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, lo};
    pwdata <= {24'h0, wd};
    pstrb <= {3'h0, st};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end else begin
      cmp("pslverr", {31'h0, ee}, {31'h0, pslverr});
      if (!w) cmp("prdata", {24'h0, ed}, prdata);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, marker_pin, cal_status} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    fail_count = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 10'h122 + 10'(16 * i), 2'h0, 1'b0, 8'h00, fuse_trim_phase0[8*i +: 8], 1'b0);
      apb(1'b0, 10'h123 + 10'(16 * i), 2'h0, 1'b0, 8'h00, fuse_trim_phase90[8*i +: 8], 1'b0);
    end
    apb(1'b0, `IDX_SAMPLE_LSB_CONTROL, 2'h0, 1'b0, 8'h00, `SAMPLE_LSB_CONTROL_RST, 1'b0);
    cmp("bank_trim", fuse_trim_phase0, bank_trim);
    $display("test reset values done");
    apb(1'b1, `IDX_SAMPLE_PATH_CONTROL, 2'h0, 1'b1, 8'h01, 8'h00, 1'b0);
    repeat (2) @(posedge pclk);
    cmp("bank_trim", fuse_trim_phase90, bank_trim);
    apb(1'b1, `IDX_BANK4_TRIM_PHASE90, 2'h0, 1'b1, 8'ha5, 8'h00, 1'b0);
    apb(1'b1, `IDX_BANK4_TRIM_PHASE90, 2'h0, 1'b0, 8'h3c, 8'h00, 1'b0);
    apb(1'b0, `IDX_BANK4_TRIM_PHASE90, 2'h0, 1'b0, 8'h00, 8'ha5, 1'b0);
    repeat (2) @(posedge pclk);
    cmp("bank4 trim", 32'ha5, {24'h0, bank_trim[23:16]});
    apb(1'b0, 10'h161, 2'h0, 1'b0, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 10'h1ff, 2'h0, 1'b1, 8'hff, 8'h00, 1'b1);
    apb(1'b0, `IDX_SAMPLE_LSB_CONTROL, 2'h2, 1'b0, 8'h00, 8'h00, 1'b1);
    $display("test trim and refusals done");
    // Marker, calibration status and 8-bit mode all on: the marker must win the LSB.
    apb(1'b1, `IDX_SAMPLE_PATH_CONTROL, 2'h0, 1'b1, 8'h0e, 8'h00, 1'b0);
    apb(1'b1, `IDX_SAMPLE_LSB_CONTROL, 2'h0, 1'b1, 8'h01, 8'h00, 1'b0);
    cal_status <= 1'b1;
    repeat (16) @(posedge pclk);
    marker_pin <= 1'b1;
    @(posedge pclk);
    marker_pin <= 1'b0;
    repeat (11) @(posedge pclk);
    @(negedge pclk);
    cmp("lsb before marker", 32'h0, {31'h0, sample_out[0]});
    @(negedge pclk);
    cmp("marker lsb", 32'h1, {31'h0, sample_out[0]});
    cmp("top bits", 32'h0, {28'h0, sample_out[11:8]});
    cmp("cs field", 32'h0, {30'h0, ila_cs_field});
    $display("test marker done");
    // Calibration status alone reaches the LSB; spare control bits keep what is written.
    apb(1'b1, `IDX_SAMPLE_PATH_CONTROL, 2'h0, 1'b1, 8'h02, 8'h00, 1'b0);
    apb(1'b1, `IDX_SAMPLE_LSB_CONTROL, 2'h0, 1'b1, 8'ha4, 8'h00, 1'b0);
    apb(1'b1, `IDX_BANK3_TRIM_PHASE0, 2'h0, 1'b1, 8'h5a, 8'h00, 1'b0);
    apb(1'b0, `IDX_SAMPLE_LSB_CONTROL, 2'h0, 1'b0, 8'h00, 8'ha4, 1'b0);
    apb(1'b0, `IDX_SAMPLE_PATH_CONTROL, 2'h0, 1'b0, 8'h00, 8'h02, 1'b0);
    apb(1'b0, `IDX_SAMPLE_PATH_STATUS, 2'h0, 1'b0, 8'h00, 8'h02, 1'b0);
    repeat (2) @(negedge pclk);
    cmp("cal lsb", 32'h1, {31'h0, sample_out[0]});
    @(negedge pclk);
    cmp("cal lsb", 32'h1, {31'h0, sample_out[0]});
    cmp("bank3 trim", 32'h5a, {24'h0, bank_trim[15:8]});
    $display("test calibration status done");
    apb(1'b1, `IDX_SAMPLE_PATH_CONTROL, 2'h0, 1'b1, 8'h00, 8'h00, 1'b0);
    apb(1'b1, `IDX_SAMPLE_LSB_CONTROL, 2'h0, 1'b1, 8'h00, 8'h00, 1'b0);
    repeat (16) @(posedge pclk);
    @(negedge pclk);
    s = sample_in;
    @(negedge pclk);
    cmp("sample", {20'h0, s}, {20'h0, sample_out});
    cmp("sample valid", 32'h1, {31'h0, sample_valid_out});
    $display("test plain samples done");
    conclude();
  end
endmodule // testbench

bind bank_timing_trim_and_lsb_marker lsb_marker_monitor i_lsb_marker_monitor (
  .pclk         (pclk),
  .presetn      (presetn),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .pwdata       (pwdata),
  .pstrb        (pstrb),
  .prdata       (prdata),
  .pready       (pready),
  .pslverr      (pslverr),
  .marker_pin   (marker_pin),
  .sample_in    (sample_in),
  .sample_out   (sample_out),
  .ila_cs_field (ila_cs_field)
);
`default_nettype wire
